/* File: core/drive_ident_regs.sv */
// identity word, fault category flags and eight-deep fault history stack
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps
`default_nettype none

module drive_ident_regs #(
  parameter logic [7:0] motor_type = drive_ident_pkg::motor_both
) (
  // clock, reset, enable
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic ce_in,
  // register port
  input wire logic [drive_ident_pkg::addr_w-1:0] addr_in,
  input wire logic [31:0] wr_data_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output drive_ident_pkg::read_answer_t rd_answer_out,
  // fault sources and events from drive logic
  input wire logic [drive_ident_pkg::categories-1:0][drive_ident_pkg::sources_per_category-1:0] fault_src_in,
  input wire drive_ident_pkg::fault_event_t fault_event_in,
  // live category flags
  output logic [7:0] fault_flags_out
);

  logic [7:0] fault_category_flags;
  logic [7:0] next_flags;
  logic [7:0] fault_history_count;
  logic [31:0] history [drive_ident_pkg::history_depth];
  logic [31:0] controller_kind_word;
  logic [15:0] obj_index;
  logic [7:0] obj_sub;
  logic count_clear;

  // constant identity; no storage so software can never alter it
  assign controller_kind_word = {8'h00, motor_type, drive_ident_pkg::profile_number};
  assign obj_index = addr_in[23:8];
  assign obj_sub = addr_in[7:0];
  assign count_clear = wr_in && obj_index == drive_ident_pkg::idx_fault_history
    && obj_sub == drive_ident_pkg::sub_count && wr_data_in[7:0] == 8'h00;

  // one OR per category; bit six stays tied low
  genvar c;
  generate
    for (c = 0; c < drive_ident_pkg::categories; c++) begin : g_flag
      if (c == drive_ident_pkg::unused_bit_six) begin : g_res
        assign next_flags[c] = 1'b0;
      end else begin : g_cat
        assign next_flags[c] = |fault_src_in[c];
      end
    end
  endgenerate

  // flags are registered from sources on each enabled clock, so they drop one clock after the fault is gone
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      fault_category_flags <= drive_ident_pkg::flags_reset;
    end else if (ce_in) begin
      fault_category_flags <= next_flags;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      fault_flags_out <= drive_ident_pkg::flags_reset;
    end else if (ce_in) begin
      fault_flags_out <= next_flags;
    end
  end

  // history shift; entries are not cleared by a count reset, only hidden while the count stays zero
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      for (int i = 0; i < drive_ident_pkg::history_depth; i++) begin
        history[i] <= drive_ident_pkg::entry_reset;
      end
    end else if (ce_in && fault_event_in.valid) begin
      history[0] <= fault_event_in.code;
      for (int i = 1; i < drive_ident_pkg::history_depth; i++) begin
        history[i] <= history[i-1];
      end
    end
  end

  // a fault in the same cycle as a clear wins: the new fault counts as one
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      fault_history_count <= drive_ident_pkg::count_reset;
    end else if (ce_in) begin
      if (fault_event_in.valid) begin
        if (count_clear) begin
          fault_history_count <= 8'h01;
        end else if (fault_history_count < drive_ident_pkg::count_max) begin
          fault_history_count <= fault_history_count + 8'h01;
        end
      end else if (count_clear) begin
        fault_history_count <= drive_ident_pkg::count_reset;
      end
    end
  end

  // read answer one cycle after the strobe; nonzero count writes are ignored
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rd_answer_out <= '0;
    end else if (ce_in) begin
      rd_answer_out <= '0;
      if (rd_in) begin
        rd_answer_out.valid <= 1'b1;
        if (obj_index == drive_ident_pkg::idx_controller_kind && obj_sub == drive_ident_pkg::sub_count) begin
          rd_answer_out.data <= controller_kind_word;
        end else if (obj_index == drive_ident_pkg::idx_fault_flags && obj_sub == drive_ident_pkg::sub_count) begin
          rd_answer_out.data <= {24'h00_0000, fault_category_flags};
        end else if (obj_index == drive_ident_pkg::idx_fault_history && obj_sub == drive_ident_pkg::sub_count) begin
          rd_answer_out.data <= {24'h00_0000, fault_history_count};
        end else if (obj_index == drive_ident_pkg::idx_fault_history && obj_sub >= drive_ident_pkg::sub_first_entry
            && obj_sub <= drive_ident_pkg::sub_last_entry) begin
          if (fault_history_count == drive_ident_pkg::count_reset) begin
            rd_answer_out.abort <= 1'b1;
            rd_answer_out.data <= drive_ident_pkg::abort_history_empty;
          end else begin
            rd_answer_out.data <= history[obj_sub[2:0] - 3'h1];
          end
        end else begin
          rd_answer_out.abort <= 1'b1;
          rd_answer_out.data <= drive_ident_pkg::abort_no_object;
        end
      end
    end
  end

endmodule
`default_nettype wire

/* File: core/drive_ident_pkg.sv */
// constants and carrier types for the identity word, fault flags and fault history
package drive_ident_pkg;
  // object indices and subindices; bus address is {index, subindex}
  localparam logic [15:0] idx_controller_kind = 16'h1000;
  localparam logic [15:0] idx_fault_flags = 16'h1001;
  localparam logic [15:0] idx_fault_history = 16'h1003;
  localparam logic [7:0] sub_count = 8'h00;
  localparam logic [7:0] sub_first_entry = 8'h01;
  localparam logic [7:0] sub_last_entry = 8'h08;
  localparam int addr_w = 24;

  // identity word fields
  localparam int motor_type_lsb = 16;
  localparam int motor_type_msb = 23;
  localparam logic [7:0] motor_bldc = 8'h02;
  localparam logic [7:0] motor_stepper = 8'h04;
  localparam logic [7:0] motor_both = 8'h06;
  localparam logic [15:0] profile_number = 16'h0192;

  // fault category flag positions
  localparam int overall_fault_flag = 0;
  localparam int amperage_fault_flag = 1;
  localparam int supply_fault_flag = 2;
  localparam int thermal_fault_flag = 3;
  localparam int link_fault_flag = 4;
  localparam int drive_standard_fault_flag = 5;
  localparam int unused_bit_six = 6;
  localparam int vendor_fault_flag = 7;
  localparam int categories = 8;
  localparam int sources_per_category = 4;

  // history geometry and reset values
  localparam int history_depth = 8;
  localparam logic [7:0] count_reset = 8'h00;
  localparam logic [7:0] flags_reset = 8'h00;
  localparam logic [31:0] entry_reset = 32'h0000_0000;
  localparam logic [7:0] count_max = 8'h08;

  // refusal codes
  localparam logic [31:0] abort_history_empty = 32'h0800_0024;
  localparam logic [31:0] abort_no_object = 32'h0000_0001;

  typedef struct packed {
    logic valid;
    logic [31:0] code;
  } fault_event_t;

  typedef struct packed {
    logic valid;
    logic abort;
    logic [31:0] data;
  } read_answer_t;
endpackage

/* File: tb/drive_ident_chk.sv */
// checker for identity word, fault flags and history of drive_ident_regs
`timescale 1ns/1ps
`default_nettype none
module drive_ident_chk #(parameter logic [7:0] motor_type = drive_ident_pkg::motor_both) (
  input wire logic clk_in, sys_rst_in, ce_in, wr_in, rd_in,
  input wire logic [23:0] addr_in,
  input wire logic [31:0] wr_data_in,
  input wire logic [7:0][3:0] fault_src_in,
  input wire drive_ident_pkg::read_answer_t rd_answer_out,
  input wire drive_ident_pkg::fault_event_t fault_event_in,
  input wire logic [7:0] fault_flags_out
);
  logic [7:0] cnt, orv;
  always_comb for (int i = 0; i < 8; i++) orv[i] = |fault_src_in[i];
  // a clear and an event together leave one entry counted
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) cnt <= 8'h00;
    else if (ce_in && wr_in && addr_in == 24'h10_0300 && wr_data_in[7:0] == 8'h00) cnt <= {7'h00, fault_event_in.valid};
    else if (ce_in && fault_event_in.valid && cnt != 8'h08) cnt <= cnt + 8'h01;
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  property p_id; ce_in && rd_in && addr_in == 24'h10_0000 |=> rd_answer_out == {2'b10, 8'h00, motor_type, 16'h0192}; endproperty
  a_id: assert property (p_id) else $error("bad identity");
  property p_b6; fault_flags_out[6] == 1'b0; endproperty
  a_b6: assert property (p_b6) else $error("bit six set");
  property p_or; ce_in |=> fault_flags_out == ($past(orv) & 8'hbf); endproperty
  a_or: assert property (p_or) else $error("bad flags");
  property p_frd; ce_in && rd_in && addr_in == 24'h10_0100 |=> rd_answer_out.data == {24'h00_0000, $past(fault_flags_out)}; endproperty
  a_frd: assert property (p_frd) else $error("bad flag read");
  property p_empty; ce_in && rd_in && addr_in[23:8] == 16'h1003 && addr_in[7:0] inside {[8'h01:8'h08]} && cnt == 8'h00
    |=> rd_answer_out == {2'b11, 32'h0800_0024}; endproperty
  a_empty: assert property (p_empty) else $error("no abort");
  property p_cnt; ce_in && rd_in && addr_in == 24'h10_0300 |=> rd_answer_out == {2'b10, 24'h00_0000, $past(cnt)}; endproperty
  a_cnt: assert property (p_cnt) else $error("bad count");
  property p_sat; ce_in && rd_in && addr_in == 24'h10_0300 |=> rd_answer_out.data <= 32'h0000_0008; endproperty
  a_sat: assert property (p_sat) else $error("count over eight");
  property p_e1; ce_in && fault_event_in.valid ##1 ce_in && rd_in && addr_in == 24'h10_0301
    |=> rd_answer_out.data == $past(fault_event_in.code, 2); endproperty
  a_e1: assert property (p_e1) else $error("bad entry one");
endmodule
bind drive_ident_regs drive_ident_chk #(.motor_type(motor_type)) drive_ident_chk_inst (.*);
`default_nettype wire

/* File: tb/fieldbus_master_model.sv */
// fieldbus master model driving the register port
`timescale 1ns/1ps
`default_nettype none
module fieldbus_master_model (
  input wire logic clk_in,
  input wire drive_ident_pkg::read_answer_t ans_in,
  output logic [23:0] addr_out,
  output logic [31:0] wdata_out,
  output logic wr_out,
  output logic rd_out
);
  initial {addr_out, wdata_out, wr_out, rd_out} = '0;
  // idle cycle after each strobe so no strobe is assigned twice in one step
  task automatic wr(input logic [23:0] a, input logic [31:0] d);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'b1;
    @(posedge clk_in) wr_out <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic rd(input logic [23:0] a, output logic [33:0] q);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clk_in) rd_out <= 1'b0;
    // answer stands in the cycle after the strobe; take it at the edge that closes that cycle
    @(posedge clk_in) q = ans_in;
  endtask
endmodule
`default_nettype wire

/* File: tb/drive_identity_and_error_stack_bench.sv */
// self-checking bench for drive_ident_regs
`timescale 1ns/1ps
`default_nettype none
module drive_identity_and_error_stack_bench;
  logic clk_in = 0, sys_rst_in = 1, ce_in = 1, wr, rd;
  logic [7:0][3:0] src = '0;
  logic [23:0] addr;
  logic [31:0] wd;
  logic [7:0] flags, e;
  drive_ident_pkg::fault_event_t ev = '0;
  drive_ident_pkg::read_answer_t ans;
  int n_errors = 0, check_count = 0;
  always #2 clk_in = ~clk_in;
  drive_ident_regs drive_ident_regs_inst (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .ce_in(ce_in), .addr_in(addr),
    .wr_data_in(wd), .wr_in(wr), .rd_in(rd), .rd_answer_out(ans), .fault_src_in(src), .fault_event_in(ev),
    .fault_flags_out(flags));
  fieldbus_master_model fieldbus_master_model_inst (.clk_in(clk_in), .ans_in(ans), .addr_out(addr), .wdata_out(wd),
    .wr_out(wr), .rd_out(rd));
  task chk(input logic [33:0] g, input logic [33:0] x);
    check_count++;
    if (g !== x) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, g, x);
    end
  endtask
  task rdc(input logic [23:0] a, input logic [33:0] x);
    logic [33:0] q;
    fieldbus_master_model_inst.rd(a, q);
    chk(q, x);
  endtask
  task t_reset;
    rdc(24'h10_0000, {2'b10, 16'h0006, 16'h0192});
    fieldbus_master_model_inst.wr(24'h10_0000, 32'hffff_ffff);
    rdc(24'h10_0000, {2'b10, 16'h0006, 16'h0192});
    rdc(24'h10_0300, {2'b10, 32'h0000_0000});
    rdc(24'h10_0308, {2'b11, 32'h0800_0024});
    rdc(24'h10_0200, {2'b11, 32'h0000_0001});
  endtask
  task t_flags;
    for (int i = 0; i < 8; i++) begin
      src <= 32'h1 << (4 * i + i % 4);
      e = (i == 6) ? 8'h00 : 8'h01 << i;
      @(posedge clk_in);
      @(negedge clk_in) chk({26'h0, flags}, {26'h0, e});
      @(posedge clk_in) rdc(24'h10_0100, {2'b10, 24'h00_0000, e});
      src <= '0;
      @(posedge clk_in);
      @(negedge clk_in) chk({26'h0, flags}, 34'h0);
      @(posedge clk_in);
    end
  endtask
  task t_hist;
    // nine faults back to back overflow the eight entries
    for (int j = 1; j <= 9; j++) begin
      ev <= {1'b1, 32'hc0de_0000 + 32'(j)};
      @(posedge clk_in);
    end
    ev <= '0;
    for (int k = 1; k <= 8; k++) rdc(24'h10_0300 + 24'(k), {2'b10, 32'hc0de_000a - 32'(k)});
    rdc(24'h10_0300, {2'b10, 32'h0000_0008});
    fieldbus_master_model_inst.wr(24'h10_0300, 32'h0000_0005);
    rdc(24'h10_0300, {2'b10, 32'h0000_0008});
    fieldbus_master_model_inst.wr(24'h10_0300, 32'h0000_0000);
    rdc(24'h10_0301, {2'b11, 32'h0800_0024});
    ev <= {1'b1, 32'hbeef_0001};
    @(posedge clk_in);
    ev <= '0;
    rdc(24'h10_0300, {2'b10, 32'h0000_0001});
    rdc(24'h10_0301, {2'b10, 32'hbeef_0001});
  endtask
  task test_done;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    @(posedge clk_in);
    t_reset;
    t_flags;
    t_hist;
    test_done;
  end
endmodule
`default_nettype wire
